// ===== pkg/vtp_pkg.sv
`default_nettype none
package vtp_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int AVS_ADDR_W = 10;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_TIMING_CONTROL = 8'h82;
   localparam logic [7:0] IDX_CM_HEADER = 8'h83;
   localparam logic [7:0] IDX_CM_PAY_HI = 8'h84;
   localparam logic [7:0] IDX_CM_PAY_LO = 8'h85;
   localparam logic [7:0] IDX_CYC_LO = 8'h86;
   localparam logic [7:0] IDX_CYC_HI = 8'h87;
   localparam logic [7:0] IDX_LINES_LO = 8'h88;
   localparam logic [7:0] IDX_LINES_HI = 8'h89;
   localparam logic [7:0] IDX_STATUS = 8'h8A;
   localparam logic [7:0] IDX_MODE = 8'h8B;
   localparam logic [7:0] IDX_BLANK = 8'h8C;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int TC_FIELD_OR_ENABLE = 7;
   localparam int TC_EMBEDDED = 5;
   localparam int TC_DISP_FRAME_POL = 4;
   localparam int TC_DISP_LINE_POL = 3;
   localparam int TC_FIELD_POL = 2;
   localparam int TC_FRAME_IN_POL = 1;
   localparam int TC_LINE_IN_POL = 0;
   localparam int CM_ENABLE_BIT = 6;
   localparam int MODE_MASTER_BIT = 3;
   localparam int XY_F_BIT = 6;
   localparam int XY_H_BIT = 4;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0] TIMING_CONTROL_RST = 8'h5F;
   localparam logic [7:0] CM_HEADER_RST = 8'h00;
   localparam logic [5:0] CM_PAY_HI_RST = 6'h00;
   localparam logic [7:0] CM_PAY_LO_RST = 8'h00;
   localparam logic [3:0] MODE_RST = 4'h0;
   localparam logic [7:0] BLANK_RST = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Presets
   localparam logic [2:0] PRESET_NONE = 3'h0;
   localparam logic [2:0] PRESET_1080P = 3'h1;
   localparam logic [2:0] PRESET_1080I = 3'h2;
   localparam logic [2:0] PRESET_720P = 3'h3;
   localparam logic [2:0] PRESET_525I = 3'h4;
   localparam logic [2:0] PRESET_525P = 3'h5;
   localparam logic [2:0] PRESET_625I = 3'h6;

   // Line type codes
   localparam logic [3:0] LT_PICTURE = 4'h0;
   localparam logic [3:0] LT_WHOLE_NORMAL_TRI = 4'h1;
   localparam logic [3:0] LT_WHOLE_BROAD_TRI = 4'h2;
   localparam logic [3:0] LT_HALF_NORMAL_TRI_PAIR = 4'h3;
   localparam logic [3:0] LT_HALF_BROAD_TRI_PAIR = 4'h4;
   localparam logic [3:0] LT_NORMAL_THEN_BROAD_TRI = 4'h5;
   localparam logic [3:0] LT_BROAD_THEN_NORMAL_TRI = 4'h6;
   localparam logic [3:0] LT_PICTURE_THEN_EQ = 4'h7;
   localparam logic [3:0] LT_NORMAL_SYNC_THEN_PICTURE = 4'h8;
   localparam logic [3:0] LT_WHOLE_NORMAL_BI = 4'h9;
   localparam logic [3:0] LT_WHOLE_BROAD_BI = 4'hA;
   localparam logic [3:0] LT_WHOLE_EQ = 4'hB;
   localparam logic [3:0] LT_EQ_PAIR = 4'hC;
   localparam logic [3:0] LT_BROAD_BI_PAIR = 4'hD;
   localparam logic [3:0] LT_BROAD_THEN_EQ = 4'hE;
   localparam logic [3:0] LT_EQ_THEN_BROAD = 4'hF;

   localparam logic [10:0] BP_NONE = 11'h7FF;
   localparam logic [10:0] FIELD_UNUSED = 11'h7FF;

   ////////////////////////////////////////////////////////////////////////
   // Timing counts
   localparam logic [10:0] CM_LINE = 11'h029;
   localparam logic [4:0] CM_BITS = 5'h14;
   localparam logic [7:0] CM_BIT_CYCLES = 8'h20;
   localparam logic [15:0] DISP_HS_LEN = 16'h0060;
   localparam logic [10:0] DISP_VS_START = 11'h003;
   localparam logic [10:0] DISP_VS_LEN = 11'h003;
   localparam logic [15:0] MASTER_LINE_CYCLES_DEF = 16'h035A;

   // Embedded code detection
   localparam logic [7:0] CODE_ONES = 8'hFF;
   localparam logic [7:0] CODE_ZEROS = 8'h00;
   typedef enum logic [1:0] {CODE_IDLE, CODE_FF, CODE_Z1, CODE_Z2} vtp_code_t;

endpackage
`default_nettype wire

// ===== src/vtp_preset_rom.sv
`timescale 1ns/1ns
`default_nettype none
module vtp_preset_rom (
   input wire logic [2:0] i_preset,
   input wire logic [3:0] i_index,
   output logic [10:0] o_breakpoint,
   output logic [3:0] o_line_type,
   output logic [10:0] o_frame_size,
   output logic [10:0] o_field_size
);
   import vtp_pkg::*;

   localparam logic [14:0] E = {BP_NONE, LT_PICTURE};

   ////////////////////////////////////////////////////////////////////////
   // Breakpoint tables, entry n ends at line {bp} - 1, the next entry starts at line {bp}
   localparam logic [14:0] T_1080P [16] = '{
      {11'h006, LT_WHOLE_BROAD_TRI}, {11'h02A, LT_WHOLE_NORMAL_TRI},
      {11'h462, LT_PICTURE}, {11'h466, LT_WHOLE_NORMAL_TRI},
      E, E, E, E, E, E, E, E, E, E, E, E};
   localparam logic [14:0] T_1080I [16] = '{
      {11'h006, LT_HALF_BROAD_TRI_PAIR}, {11'h007, LT_HALF_NORMAL_TRI_PAIR},
      {11'h015, LT_WHOLE_NORMAL_TRI}, {11'h231, LT_PICTURE},
      {11'h233, LT_WHOLE_NORMAL_TRI}, {11'h234, LT_NORMAL_THEN_BROAD_TRI},
      {11'h238, LT_HALF_BROAD_TRI_PAIR}, {11'h239, LT_BROAD_THEN_NORMAL_TRI},
      {11'h248, LT_WHOLE_NORMAL_TRI}, {11'h464, LT_PICTURE},
      {11'h466, LT_WHOLE_NORMAL_TRI}, E, E, E, E, E};
   localparam logic [14:0] T_720P [16] = '{
      {11'h006, LT_WHOLE_BROAD_TRI}, {11'h01A, LT_WHOLE_NORMAL_TRI},
      {11'h2EA, LT_PICTURE}, {11'h2EF, LT_WHOLE_NORMAL_TRI},
      E, E, E, E, E, E, E, E, E, E, E, E};
   localparam logic [14:0] T_525I [16] = '{
      {11'h004, LT_EQ_PAIR}, {11'h007, LT_BROAD_BI_PAIR},
      {11'h00A, LT_EQ_PAIR}, {11'h014, LT_WHOLE_NORMAL_BI},
      {11'h107, LT_PICTURE}, {11'h108, LT_PICTURE_THEN_EQ},
      {11'h10A, LT_EQ_PAIR}, {11'h10B, LT_EQ_THEN_BROAD},
      {11'h10D, LT_BROAD_BI_PAIR}, {11'h10E, LT_BROAD_THEN_EQ},
      {11'h110, LT_EQ_PAIR}, {11'h111, LT_WHOLE_EQ},
      {11'h11A, LT_WHOLE_NORMAL_BI}, {11'h11B, LT_NORMAL_SYNC_THEN_PICTURE},
      {11'h20E, LT_PICTURE}, E};
   localparam logic [14:0] T_525P [16] = '{
      {11'h00A, LT_WHOLE_NORMAL_BI}, {11'h010, LT_WHOLE_BROAD_BI},
      {11'h02E, LT_WHOLE_NORMAL_BI}, {11'h20E, LT_PICTURE},
      E, E, E, E, E, E, E, E, E, E, E, E};
   localparam logic [14:0] T_625I [16] = '{
      {11'h003, LT_BROAD_BI_PAIR}, {11'h004, LT_BROAD_THEN_EQ},
      {11'h006, LT_EQ_PAIR}, {11'h017, LT_WHOLE_NORMAL_BI},
      {11'h018, LT_NORMAL_SYNC_THEN_PICTURE}, {11'h137, LT_PICTURE},
      {11'h139, LT_EQ_PAIR}, {11'h13A, LT_EQ_THEN_BROAD},
      {11'h13C, LT_BROAD_BI_PAIR}, {11'h13E, LT_EQ_PAIR},
      {11'h13F, LT_WHOLE_EQ}, {11'h150, LT_WHOLE_NORMAL_BI},
      {11'h26F, LT_PICTURE}, {11'h270, LT_PICTURE_THEN_EQ},
      {11'h272, LT_EQ_PAIR}, E};

   logic [14:0] entry;

   always_comb begin
      entry = E;
      o_frame_size = BP_NONE;
      o_field_size = FIELD_UNUSED;
      case (i_preset)
         PRESET_1080P: begin
            entry = T_1080P[i_index];
            o_frame_size = 11'h465;
         end
         PRESET_1080I: begin
            entry = T_1080I[i_index];
            o_frame_size = 11'h465;
            o_field_size = 11'h233;
         end
         PRESET_720P: begin
            entry = T_720P[i_index];
            o_frame_size = 11'h2EE;
         end
         PRESET_525I: begin
            entry = T_525I[i_index];
            o_frame_size = 11'h20D;
            o_field_size = 11'h107;
         end
         PRESET_525P: begin
            entry = T_525P[i_index];
            o_frame_size = 11'h20D;
         end
         PRESET_625I: begin
            entry = T_625I[i_index];
            o_frame_size = 11'h271;
            o_field_size = 11'h138;
         end
         default: begin
            entry = E;
         end
      endcase
   end

   assign o_breakpoint = entry[14:4];
   assign o_line_type = entry[3:0];
endmodule // vtp_preset_rom
`default_nettype wire

// ===== src/vtp_timing.sv
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Frame sync input polarity bit 1, reset high
// - Line sync input polarity bit 0, reset high
// - Read back sixteen-bit cycles per line count
// - Read back sixteen-bit line syncs per frame
// - Copy data on line 41 in 525/625 presets when enabled
// - Copy content is header plus fourteen-bit payload
// - Preset selects breakpoint list and frame sizes
// - 1080 progressive breakpoint table, 1125 lines
// - 1080 interlaced table, first field of 563
// - 720 progressive table, 750 lines
// - 525 interlaced table, field 263
// - 525 progressive table, 525 lines
// - 625 interlaced table, field 312
// - Progressive presets mark field size all ones
// - Slave follows dedicated syncs or embedded codes
// - Master drives syncs to source, ignores field
// - Master keeps driving display syncs too
// - Data enable blanks samples outside window, graphics (no preset) only
// - Field derived from line/frame sync alignment
// - Line type holds until next breakpoint
// - Control bit 7 selects field or enable
// - Control bit 5 selects embedded code timing
module vtp_timing #(
   parameter logic [15:0] MASTER_LINE_CYCLES =
      vtp_pkg::MASTER_LINE_CYCLES_DEF
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [vtp_pkg::AVS_ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_line_sync_terminal,
   output logic o_line_sync_terminal,
   output logic o_line_sync_terminal_oe,
   input wire logic i_frame_sync_terminal,
   output logic o_frame_sync_terminal,
   output logic o_frame_sync_terminal_oe,
   input wire logic i_field_or_enable,
   input wire logic [7:0] i_video_data,
   output logic [7:0] o_video_data,
   output logic o_display_line_sync,
   output logic o_display_frame_sync,
   output logic o_field_id,
   output logic [3:0] o_line_type,
   output logic o_copy_mgmt_bit,
   output logic o_copy_mgmt_active
);
   import vtp_pkg::*;

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic [7:0] cm_hdr;
      logic [5:0] pay_hi;
      logic [7:0] pay_lo;
      logic [3:0] mode;
      logic [7:0] blank;
      logic ls_prev;
      logic fs_prev;
      vtp_code_t code;
      logic f_prev;
      logic [15:0] h_cnt;
      logic [15:0] ppl;
      logic [15:0] lpf_cnt;
      logic [15:0] lpf;
      logic [10:0] line;
      logic [3:0] bp_idx;
      logic [3:0] ltype;
      logic field;
      logic [19:0] cm_shift;
      logic [4:0] cm_left;
      logic [7:0] cm_div;
      logic cm_act;
      logic disp_hs;
      logic disp_vs;
      logic src_hs;
      logic src_vs;
      logic [7:0] vid;
   } vtp_state_t;

   localparam vtp_state_t ST_RST = '{
      ctrl: TIMING_CONTROL_RST,
      cm_hdr: CM_HEADER_RST,
      pay_hi: CM_PAY_HI_RST,
      pay_lo: CM_PAY_LO_RST,
      mode: MODE_RST,
      blank: BLANK_RST,
      code: CODE_IDLE,
      line: 11'h001,
      default: '0
   };

   vtp_state_t q;
   vtp_state_t d;

   logic master;
   logic embedded;
   logic fod_sel;
   logic [2:0] preset;
   logic graphics;
   logic sd_mode;
   logic interlaced;
   logic derive_field;
   logic ls_n;
   logic fs_n;
   logic fid_n;
   logic eav;
   logic f_bit;
   logic line_ev;
   logic frame_ev;
   logic [10:0] rom_bp;
   logic [3:0] rom_type;
   logic [10:0] rom_frame;
   logic [10:0] rom_field;
   logic req;
   logic addr_ok;
   logic [7:0] reg_idx;
   logic wr_take;
   logic [31:0] rd_mux;
   logic hs_on;
   logic vs_on;

   ////////////////////////////////////////////////////////////////////////
   // Preset tables
   vtp_preset_rom u_rom (
      .i_preset(preset),
      .i_index(q.bp_idx),
      .o_breakpoint(rom_bp),
      .o_line_type(rom_type),
      .o_frame_size(rom_frame),
      .o_field_size(rom_field)
   );

   ////////////////////////////////////////////////////////////////////////
   // Mode decode and sync events
   assign master = q.mode[MODE_MASTER_BIT];
   assign preset = q.mode[2:0];
   assign embedded = q.ctrl[TC_EMBEDDED];
   assign fod_sel = q.ctrl[TC_FIELD_OR_ENABLE];
   assign graphics = (preset == PRESET_NONE);
   assign sd_mode = (preset == PRESET_525I) || (preset == PRESET_525P) ||
      (preset == PRESET_625I);
   assign interlaced = (rom_field != FIELD_UNUSED);
   assign derive_field = fod_sel && !embedded && !graphics && !master;

   // Inputs reduced to active-high before any edge is looked for
   assign ls_n = i_line_sync_terminal ^ ~q.ctrl[TC_LINE_IN_POL];
   assign fs_n = i_frame_sync_terminal ^ ~q.ctrl[TC_FRAME_IN_POL];
   assign fid_n = i_field_or_enable ^ ~q.ctrl[TC_FIELD_POL];

   assign f_bit = i_video_data[XY_F_BIT];
   assign eav = (q.code == CODE_Z2) && i_video_data[XY_H_BIT];

   // Slave events follow the source; master events come from own counters
   always_comb begin
      if (master) begin
         line_ev = (q.h_cnt == MASTER_LINE_CYCLES - 16'h0001);
         frame_ev = line_ev && (q.line == rom_frame);
      end else if (embedded) begin
         line_ev = eav;
         frame_ev = eav && q.f_prev && !f_bit;
      end else begin
         line_ev = ls_n && !q.ls_prev;
         frame_ev = fs_n && !q.fs_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register bus decode
   assign req = i_avs_read || i_avs_write;
   assign addr_ok = (i_avs_address[1:0] == 2'h0);
   assign reg_idx = i_avs_address[AVS_ADDR_W-1:2];
   assign wr_take = i_avs_write && q.ack && addr_ok && i_avs_byteenable[0];
   assign o_avs_waitrequest = req && !q.ack;
   assign o_avs_readdata = q.rdata;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (addr_ok) begin
         case (reg_idx)
            IDX_TIMING_CONTROL: rd_mux[7:0] = q.ctrl;
            IDX_CM_HEADER: rd_mux[6:0] = q.cm_hdr[6:0];
            IDX_CM_PAY_HI: rd_mux[5:0] = q.pay_hi;
            IDX_CM_PAY_LO: rd_mux[7:0] = q.pay_lo;
            IDX_CYC_LO: rd_mux[7:0] = q.ppl[7:0];
            IDX_CYC_HI: rd_mux[7:0] = q.ppl[15:8];
            IDX_LINES_LO: rd_mux[7:0] = q.lpf[7:0];
            IDX_LINES_HI: rd_mux[7:0] = q.lpf[15:8];
            IDX_STATUS: rd_mux[6:0] = {q.cm_act, interlaced, q.field, q.ltype};
            IDX_MODE: rd_mux[3:0] = q.mode;
            IDX_BLANK: rd_mux[7:0] = q.blank;
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      d = q;

      // One wait cycle per access, read data captured with the answer
      d.ack = req && !q.ack;
      if (req && !q.ack) begin
         d.rdata = rd_mux;
      end
      if (wr_take) begin
         case (reg_idx)
            IDX_TIMING_CONTROL: d.ctrl = i_avs_writedata[7:0];
            IDX_CM_HEADER: d.cm_hdr = {1'b0, i_avs_writedata[6:0]};
            IDX_CM_PAY_HI: d.pay_hi = i_avs_writedata[5:0];
            IDX_CM_PAY_LO: d.pay_lo = i_avs_writedata[7:0];
            IDX_MODE: d.mode = i_avs_writedata[3:0];
            IDX_BLANK: d.blank = i_avs_writedata[7:0];
            default: d.ctrl = q.ctrl;
         endcase
      end

      d.ls_prev = ls_n;
      d.fs_prev = fs_n;

      // Embedded code search: ones, zeros, zeros, then the status word
      unique case (q.code)
         CODE_IDLE: begin
            d.code = (i_video_data == CODE_ONES) ? CODE_FF : CODE_IDLE;
         end
         CODE_FF: begin
            if (i_video_data == CODE_ZEROS) begin
               d.code = CODE_Z1;
            end else if (i_video_data == CODE_ONES) begin
               d.code = CODE_FF;
            end else begin
               d.code = CODE_IDLE;
            end
         end
         CODE_Z1: begin
            d.code = (i_video_data == CODE_ZEROS) ? CODE_Z2 : CODE_IDLE;
         end
         CODE_Z2: begin
            d.code = CODE_IDLE;
         end
      endcase
      if (eav) begin
         d.f_prev = f_bit;
      end

      // Cycle count between line events
      if (line_ev) begin
         d.h_cnt = 16'h0000;
         d.ppl = q.h_cnt + 16'h0001;
      end else begin
         d.h_cnt = q.h_cnt + 16'h0001;
      end

      // Line count over a frame
      if (frame_ev) begin
         d.lpf = q.lpf_cnt;
         d.lpf_cnt = {15'h0000, line_ev};
      end else if (line_ev) begin
         d.lpf_cnt = q.lpf_cnt + 16'h0001;
      end

      // Line counter and breakpoint walk
      if (frame_ev) begin
         d.line = 11'h001;
         d.bp_idx = 4'h0;
      end else if (line_ev) begin
         d.line = q.line + 11'h001;
         if (d.line == rom_bp) begin
            d.bp_idx = q.bp_idx + 4'h1;
         end
      end
      d.ltype = rom_type;

      // Field identity
      if (master) begin
         d.field = interlaced && (q.line > rom_field);
      end else if (derive_field) begin
         if (frame_ev) begin
            d.field = (q.h_cnt >= {1'b0, q.ppl[15:1]});
         end
      end else if (embedded) begin
         if (eav) begin
            d.field = f_bit;
         end
      end else begin
         d.field = fid_n && interlaced;
      end

      // Copy-management insertion, header first, shifted out MSB first
      if (line_ev && !frame_ev && (d.line == CM_LINE) && sd_mode &&
          q.cm_hdr[CM_ENABLE_BIT]) begin
         d.cm_shift = {q.cm_hdr[5:0], q.pay_hi, q.pay_lo};
         d.cm_left = CM_BITS;
         d.cm_div = 8'h00;
         d.cm_act = 1'b1;
      end else if (q.cm_act) begin
         if (q.cm_div == CM_BIT_CYCLES - 8'h01) begin
            d.cm_div = 8'h00;
            d.cm_shift = {q.cm_shift[18:0], 1'b0};
            d.cm_left = q.cm_left - 5'h01;
            d.cm_act = (q.cm_left != 5'h01);
         end else begin
            d.cm_div = q.cm_div + 8'h01;
         end
      end

      // Display and source syncs
      hs_on = (d.h_cnt < DISP_HS_LEN);
      vs_on = (d.line >= DISP_VS_START) &&
         (d.line < DISP_VS_START + DISP_VS_LEN);
      d.disp_hs = hs_on ^ ~q.ctrl[TC_DISP_LINE_POL];
      d.disp_vs = vs_on ^ q.ctrl[TC_DISP_FRAME_POL];
      d.src_hs = hs_on ^ ~q.ctrl[TC_LINE_IN_POL];
      d.src_vs = vs_on ^ ~q.ctrl[TC_FRAME_IN_POL];

      // Graphics data enable replaces samples outside the window
      if (fod_sel && graphics && !i_field_or_enable) begin
         d.vid = q.blank;
      end else begin
         d.vid = i_video_data;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign o_line_sync_terminal = q.src_hs;
   assign o_frame_sync_terminal = q.src_vs;
   assign o_line_sync_terminal_oe = master;
   assign o_frame_sync_terminal_oe = master;
   assign o_display_line_sync = q.disp_hs;
   assign o_display_frame_sync = q.disp_vs;
   assign o_video_data = q.vid;
   assign o_field_id = q.field;
   assign o_line_type = q.ltype;
   assign o_copy_mgmt_bit = q.cm_shift[19];
   assign o_copy_mgmt_active = q.cm_act;
endmodule // vtp_timing
`default_nettype wire

// ===== test/tb_video_timing_preset_and_sync_control.sv
`timescale 1ns/1ns
`default_nettype none
module tb_video_timing_preset_and_sync_control;
   import vtp_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic fe = 1'b0, pol = 1'b1, sel = 1'b0;
   logic [9:0] ad = 10'h000;
   logic [31:0] wd = 32'h0, rdat;
   logic [3:0] be = 4'hF, lt;
   logic [7:0] len = 8'h78, sd, vd, cyc, q;
   logic [10:0] nl = 11'h00C, ln;
   logic wq, lso, lsoe, fso, fsoe, dls, dfs, fid, cmb, cma, mhs, mvs;
   logic [19:0] cw = {6'h2A, 6'h15, 8'hC3};
   logic [10:0] lns [3] = '{11'h005, 11'h00C, 11'h01E};
   logic [3:0] lts [3] = '{LT_WHOLE_NORMAL_BI, LT_WHOLE_BROAD_BI,
      LT_WHOLE_NORMAL_BI};
   int num_errors = 0, cmp_count = 0, ncyc = 0, i, p;
   wire logic hs = lsoe ? lso : mhs;
   wire logic vs = fsoe ? fso : mvs;
   wire logic ms = sel ? dls : lso;
   vtp_timing #(.MASTER_LINE_CYCLES(16'h00C8)) dut (.i_ref_clk(clk),
      .i_rst_n(rst_n), .i_avs_address(ad), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
      .o_avs_readdata(rdat), .o_avs_waitrequest(wq),
      .i_line_sync_terminal(hs), .o_line_sync_terminal(lso),
      .o_line_sync_terminal_oe(lsoe), .i_frame_sync_terminal(vs),
      .o_frame_sync_terminal(fso), .o_frame_sync_terminal_oe(fsoe),
      .i_field_or_enable(fe), .i_video_data(sd), .o_video_data(vd),
      .o_display_line_sync(dls), .o_display_frame_sync(dfs),
      .o_field_id(fid), .o_line_type(lt), .o_copy_mgmt_bit(cmb),
      .o_copy_mgmt_active(cma));
   vtp_source_model src (.i_ref_clk(clk), .i_rst_n(rst_n), .i_len(len),
      .i_lines(nl), .i_pol(pol), .o_hs(mhs), .o_vs(mvs), .o_data(sd),
      .o_line(ln), .o_cyc(cyc));
   ////////////////////////////////////////
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [19:0] g, input logic [19:0] e,
      input string m);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %0t %s got %h", $time, m, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] ix,
      input logic [7:0] d);
      @(posedge clk);
      ad <= {ix, 2'b00};
      rd <= !w;
      wr <= w;
      wd <= {24'h000000, d};
      // Answer is taken at the edge where waitrequest is seen low
      do @(posedge clk); while (wq !== 1'b0);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
      bus(1'b0, ix, 8'h00);
      chk(q, e, "register");
   endtask
   task automatic wl(input logic [10:0] l, input logic [7:0] c);
      do @(posedge clk); while (!(ln == l && cyc == c));
   endtask
   task automatic per();
      realtime t0;
      @(posedge ms);
      t0 = $realtime;
      @(posedge ms);
      p = int'(($realtime - t0) / 100.0);
   endtask
   ////////////////////////////////////////
   initial begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      ncyc++;
      if (ncyc == 60000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rdc(IDX_TIMING_CONTROL, 8'h5F);
      rdc(IDX_CM_HEADER, 8'h00);
      rdc(IDX_CM_PAY_HI, 8'h00);
      rdc(IDX_CM_PAY_LO, 8'h00);
      rdc(IDX_MODE, 8'h00);
      rdc(8'h90, 8'h00);
      bus(1'b1, IDX_CYC_HI, 8'hFF);
      be <= 4'hE;
      bus(1'b1, IDX_BLANK, 8'h55);
      be <= 4'hF;
      rdc(IDX_BLANK, 8'h00);
      $display("test registers done");
      repeat (3000) @(posedge clk);
      rdc(IDX_CYC_HI, 8'h00);
      rdc(IDX_CYC_LO, 8'h78);
      rdc(IDX_LINES_HI, 8'h00);
      rdc(IDX_LINES_LO, 8'h0C);
      for (i = 0; i < 2; i++) begin
         if (i == 1) begin
            pol <= 1'b0;
            bus(1'b1, IDX_TIMING_CONTROL, 8'h5C);
         end
         wl(11'h005, 8'h03);
         chk(dls, 1'b1, "line sync start");
         wl(11'h005, 8'h6E);
         chk(dls, 1'b0, "line sync end");
      end
      $display("test polarity done");
      pol <= 1'b1;
      fe <= 1'b1;
      len <= 8'h28;
      nl <= 11'h20D;
      bus(1'b1, IDX_TIMING_CONTROL, 8'h5F);
      bus(1'b1, IDX_MODE, {5'h00, PRESET_525P});
      bus(1'b1, IDX_CM_HEADER, 8'h6A);
      bus(1'b1, IDX_CM_PAY_HI, 8'h15);
      bus(1'b1, IDX_CM_PAY_LO, 8'hC3);
      // Line count realigned by the next frame start
      wl(11'h001, 8'h01);
      for (i = 0; i < 3; i++) begin
         wl(lns[i], 8'h14);
         chk(lt, lts[i], "line type");
         chk(dfs, lns[i] > 11'h005, "frame sync");
         chk(fid, 1'b0, "progressive field");
      end
      do @(posedge clk); while (cma !== 1'b1);
      chk(ln, 11'h029, "copy line");
      for (i = 0; i < 20; i++) begin
         repeat (16) @(posedge clk);
         chk(cmb, cw[19-i], "copy bit");
         repeat (16) @(posedge clk);
      end
      wl(11'h064, 8'h14);
      chk(lt, LT_PICTURE, "picture type");
      $display("test preset done");
      bus(1'b1, IDX_MODE, 8'h08);
      @(posedge clk);
      chk(lsoe & fsoe, 1'b1, "sync enable");
      per();
      chk(p[19:0], 20'h000C8, "source line period");
      chk(fso, 1'b0, "source frame sync");
      sel <= 1'b1;
      per();
      chk(p[19:0], 20'h000C8, "display line period");
      $display("test master done");
      fe <= 1'b0;
      bus(1'b1, IDX_MODE, 8'h00);
      bus(1'b1, IDX_BLANK, 8'h10);
      bus(1'b1, IDX_TIMING_CONTROL, 8'hDF);
      repeat (2) @(posedge clk);
      chk(vd, 8'h10, "blanked sample");
      fe <= 1'b1;
      repeat (2) @(posedge clk);
      chk(vd, 8'(sd - 8'h01), "passed sample");
      $display("test video done");
      finish_test();
   end
endmodule // tb_video_timing_preset_and_sync_control
bind vtp_timing vtp_timing_assertions u_chk (.i_ref_clk(i_ref_clk),
   .i_rst_n(i_rst_n), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .o_line_sync_terminal_oe(o_line_sync_terminal_oe),
   .o_frame_sync_terminal_oe(o_frame_sync_terminal_oe),
   .o_copy_mgmt_bit(o_copy_mgmt_bit),
   .o_copy_mgmt_active(o_copy_mgmt_active));
`default_nettype wire

// ===== test/vtp_source_model.sv
`timescale 1ns/1ns
`default_nettype none
module vtp_source_model (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_len,
   input wire logic [10:0] i_lines,
   input wire logic i_pol,
   output logic o_hs,
   output logic o_vs,
   output logic [7:0] o_data,
   output logic [10:0] o_line,
   output logic [7:0] o_cyc
);
   ////////////////////////////////////////
   logic act;
   assign act = o_cyc < 8'h04;
   // Pulses in the polarity software is told to expect
   assign o_hs = act ~^ i_pol;
   assign o_vs = (act && o_line == 11'h001) ~^ i_pol;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         o_cyc <= 8'h00;
         o_line <= 11'h001;
         o_data <= 8'h00;
      end else begin
         o_data <= o_data + 8'h01;
         if (o_cyc == i_len - 8'h01) begin
            o_cyc <= 8'h00;
            o_line <= (o_line == i_lines) ? 11'h001 : o_line + 11'h001;
         end else begin
            o_cyc <= o_cyc + 8'h01;
         end
      end
   end
endmodule // vtp_source_model
`default_nettype wire

// ===== test/vtp_timing_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module vtp_timing_assertions (
   input wire logic i_ref_clk,
   input wire logic i_rst_n,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic o_line_sync_terminal_oe,
   input wire logic o_frame_sync_terminal_oe,
   input wire logic o_copy_mgmt_bit,
   input wire logic o_copy_mgmt_active
);
   ////////////////////////////////////////
   logic [9:0] cnt_q;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   // Cycles spent inside the current copy insertion
   always_ff @(posedge i_ref_clk) begin
      cnt_q <= o_copy_mgmt_active ? cnt_q + 10'h001 : 10'h000;
   end
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_ack;
      !o_avs_waitrequest;
   endsequence
   a_one_wait: assert property (s_req |=> s_ack)
      else $error("bus answer late");
   a_idle_nowait: assert property
      (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
      else $error("wait without request");
   a_rdata_upper: assert property (o_avs_readdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
   a_oe_pair: assert property (
      o_line_sync_terminal_oe == o_frame_sync_terminal_oe)
      else $error("sync enables differ");
   a_oe_by_write: assert property ($changed(o_line_sync_terminal_oe) &&
      $past(i_rst_n) |-> $past(i_avs_write && !o_avs_waitrequest))
      else $error("sync enable moved without write");
   a_copy_len: assert property (
      $fell(o_copy_mgmt_active) |-> cnt_q == 10'h280)
      else $error("copy insertion length wrong");
   a_copy_idle: assert property (!o_copy_mgmt_active |-> !o_copy_mgmt_bit)
      else $error("copy bit while idle");
   a_bit_period: assert property ($changed(o_copy_mgmt_bit) &&
      o_copy_mgmt_active && $past(o_copy_mgmt_active) |-> cnt_q[4:0] == 5'h00)
      else $error("copy bit off period");
endmodule // vtp_timing_assertions
`default_nettype wire
